/* verilog/cph_params.svh */
`ifndef CPH_PARAMS_SVH
`define CPH_PARAMS_SVH

// ****************************************
// Widths
// ****************************************
`define CPH_ADDR_W     14
`define CPH_BA_W       3
`define CPH_DQ_W       8
`define CPH_MAX_RATIO  4
`define CPH_LANE_W     2
`define CPH_LAT_W      6
`define CPH_MAX_RLAT   32

// ****************************************
// Timing
// ****************************************
`define CPH_CLK_MHZ    200
`define CPH_INIT_US    200
`define CPH_INIT_CYC   (`CPH_INIT_US * `CPH_CLK_MHZ)
`define CPH_MRD_NS     10
`define CPH_MRD_CYC    ((`CPH_MRD_NS * `CPH_CLK_MHZ + 999) / 1000)

// ****************************************
// Latencies and mode register values
// ****************************************
`define CPH_RATIO      2
`define CPH_WR_LAT     2
`define CPH_RD_LAT     15
`define CPH_CAP_TICKS  4
`define CPH_NUM_MRS    4
`define CPH_MR0        14'h0520
`define CPH_MR1        14'h0044
`define CPH_MR2        14'h0008
`define CPH_MR3        14'h0000

`endif

/* verilog/cph_pkg.sv */
`include "cph_params.svh"

package cph_pkg;

   typedef struct packed {
      logic                   cs_n;
      logic                   ras_n;
      logic                   cas_n;
      logic                   we_n;
      logic [`CPH_BA_W-1:0]   ba;
      logic [`CPH_ADDR_W-1:0] addr;
   } cph_cmd_type;

   localparam cph_cmd_type CPH_NOP = '{cs_n: 1'b1, ras_n: 1'b1,
      cas_n: 1'b1, we_n: 1'b1, ba: '0, addr: '0};

   // One memory clock cycle: rising-edge data in the low byte
   typedef struct packed {
      cph_cmd_type              cmd;
      logic [2*`CPH_DQ_W-1:0]   wd;
      logic                     wv;
      logic                     dqs;
   } cph_beat_type;

   typedef struct packed {
      cph_beat_type [`CPH_MAX_RATIO-1:0] lane;
   } cph_word_type;

   typedef logic [`CPH_MAX_RATIO-1:0][2*`CPH_DQ_W-1:0] cph_rword_type;

   typedef enum logic [1:0] {
      ADM_WAIT,
      ADM_MRS,
      ADM_GAP,
      ADM_DONE
   } cph_adm_state_type;

   typedef struct packed {
      cph_adm_state_type      state;
      logic [15:0]            cnt;
      logic [1:0]             idx;
      cph_cmd_type            cmd;
      logic                   done;
      logic [`CPH_LAT_W-1:0]  wlat;
      logic [`CPH_LAT_W-1:0]  rlat;
   } cph_adm_state_rec_type;

   typedef struct packed {
      logic [`CPH_LANE_W-1:0]            cnt;
      logic                              tick;
      cph_word_type                      w;
      cph_beat_type                      mem;
      logic [2*`CPH_DQ_W-1:0]            dq_s1;
      logic [2*`CPH_DQ_W-1:0]            dq_s2;
      cph_rword_type                     rcap;
      logic [`CPH_MAX_RLAT-1:0]          en_sh;
      cph_rword_type [`CPH_MAX_RLAT-1:0] d_sh;
      cph_rword_type                     rdata;
      logic                              rvalid;
   } cph_top_state_type;

endpackage

/* verilog/cph_admin.sv */
`timescale 1ns/10ps
`include "cph_params.svh"

module cph_admin #(
   parameter int INIT_CYC = `CPH_INIT_CYC,
   parameter int WR_LAT   = `CPH_WR_LAT,
   parameter int RD_LAT   = `CPH_RD_LAT
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   output cph_pkg::cph_cmd_type       cmd,
   output logic                       done,
   output logic [`CPH_LAT_W-1:0]      wlat,
   output logic [`CPH_LAT_W-1:0]      rlat
);

   localparam logic [15:0] INIT_LAST = 16'(INIT_CYC - 1);
   localparam logic [15:0] MRD_LAST  = 16'(`CPH_MRD_CYC - 1);
   localparam logic [1:0]  MRS_LAST  = 2'(`CPH_NUM_MRS - 1);

   if (INIT_CYC < 1 || INIT_CYC > 65536) begin : g_chk_init
      $error("cph_admin: INIT_CYC out of range");
   end

   cph_pkg::cph_adm_state_rec_type st;
   cph_pkg::cph_adm_state_rec_type next_st;

   function automatic logic [`CPH_ADDR_W-1:0] mr_value(
      input logic [1:0] i);
      case (i)
         2'h0:    mr_value = `CPH_MR0;
         2'h1:    mr_value = `CPH_MR1;
         2'h2:    mr_value = `CPH_MR2;
         default: mr_value = `CPH_MR3;
      endcase
   endfunction

   always_comb begin
      next_st = st;
      next_st.cmd = cph_pkg::CPH_NOP;
      case (st.state)
         // ****************************************
         // Power-up wait before the memory may be touched
         // ****************************************
         cph_pkg::ADM_WAIT: begin
            next_st.cnt = st.cnt + 16'h0001;
            if (st.cnt == INIT_LAST) begin
               next_st.cnt = 16'h0000;
               next_st.state = cph_pkg::ADM_MRS;
            end
         end
         cph_pkg::ADM_MRS: begin
            next_st.cmd = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0,
               we_n: 1'b0, ba: `CPH_BA_W'(st.idx),
               addr: mr_value(st.idx)};
            next_st.cnt = 16'h0000;
            next_st.state = cph_pkg::ADM_GAP;
         end
         cph_pkg::ADM_GAP: begin
            next_st.cnt = st.cnt + 16'h0001;
            if (st.cnt == MRD_LAST) begin
               next_st.cnt = 16'h0000;
               if (st.idx == MRS_LAST) begin
                  next_st.state = cph_pkg::ADM_DONE;
               end else begin
                  next_st.idx = st.idx + 2'h1;
                  next_st.state = cph_pkg::ADM_MRS;
               end
            end
         end
         cph_pkg::ADM_DONE: begin
            // Latencies are reported only once the memory is ready
            next_st.done = 1'b1;
            next_st.wlat = `CPH_LAT_W'(WR_LAT);
            next_st.rlat = `CPH_LAT_W'(RD_LAT);
         end
         default: begin
            next_st.state = cph_pkg::ADM_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st     <= '0;
         st.cmd <= cph_pkg::CPH_NOP;
      end else begin
         st <= next_st;
      end
   end

   assign cmd  = st.cmd;
   assign done = st.done;
   assign wlat = st.wlat;
   assign rlat = st.rlat;

endmodule

/* verilog/cph_top.sv */
`timescale 1ns/10ps
`include "cph_params.svh"


module cph_top #(
   parameter int RATIO     = `CPH_RATIO,
   parameter int INIT_CYC  = `CPH_INIT_CYC,
   parameter int WR_LAT    = `CPH_WR_LAT,
   parameter int RD_LAT    = `CPH_RD_LAT,
   parameter int CAP_TICKS = `CPH_CAP_TICKS
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   output logic                        ctl_tick,
   input  wire cph_pkg::cph_word_type  ctl_word,
   input  wire logic [`CPH_MAX_RATIO-1:0] ctl_rdata_en,
   output cph_pkg::cph_rword_type      ctl_rdata,
   output logic                        ctl_rdata_valid,
   output logic                        ctl_cal_done,
   output logic [`CPH_LAT_W-1:0]       ctl_wlat,
   output logic [`CPH_LAT_W-1:0]       ctl_rlat,
   output cph_pkg::cph_cmd_type        mem_cmd,
   output logic [2*`CPH_DQ_W-1:0]      mem_dq_out,
   output logic                        mem_dq_oe,
   output logic                        mem_dqs_oe,
   input  wire logic [2*`CPH_DQ_W-1:0] mem_dq_in
);

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (RATIO != 1 && RATIO != 2 && RATIO != 4) begin : g_chk_ratio
      $error("cph_top: RATIO must be 1, 2 or 4");
   end
   if (RD_LAT < 2 || RD_LAT > `CPH_MAX_RLAT) begin : g_chk_rlat
      $error("cph_top: RD_LAT out of range");
   end
   if (CAP_TICKS < 0 || CAP_TICKS >= RD_LAT) begin : g_chk_cap
      $error("cph_top: CAP_TICKS must be below RD_LAT");
   end
   if (WR_LAT < 0 || WR_LAT > 63) begin : g_chk_wlat
      $error("cph_top: WR_LAT out of range");
   end

   localparam logic [`CPH_LANE_W-1:0] LAST =
      `CPH_LANE_W'(RATIO - 1);
   localparam logic [`CPH_MAX_RATIO-1:0] LMASK =
      `CPH_MAX_RATIO'((1 << RATIO) - 1);

   cph_pkg::cph_top_state_type st;
   cph_pkg::cph_top_state_type next_st;
   cph_pkg::cph_cmd_type       adm_cmd;
   logic                       adm_done;

   // ****************************************
   // Administration and latency report
   // ****************************************
   cph_admin #(
      .INIT_CYC (INIT_CYC),
      .WR_LAT   (WR_LAT),
      .RD_LAT   (RD_LAT)
   ) u_admin (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cmd     (adm_cmd),
      .done    (adm_done),
      .wlat    (ctl_wlat),
      .rlat    (ctl_rlat)
   );

   always_comb begin
      cph_pkg::cph_word_type src;
      logic                  en_in;
      src = ctl_word;
      en_in = 1'b0;
      next_st = st;

      // ****************************************
      // Controller cycle divider
      // ****************************************
      next_st.cnt = (st.cnt == LAST) ? '0 : st.cnt + 1'b1;
      next_st.tick = (next_st.cnt == LAST);

      // ****************************************
      // Write and command serialiser
      // ****************************************
      // Whole word is taken at once on the tick edge
      if (st.tick) begin
         next_st.w = ctl_word;
      end else begin
         src = st.w;
      end
      // Lane index equals the memory cycle within the controller cycle
      next_st.mem = src.lane[next_st.cnt];
      // Controller traffic is ignored until mode registers are set
      if (!adm_done) begin
         next_st.mem.cmd = adm_cmd;
         next_st.mem.wv = 1'b0;
         next_st.mem.dqs = 1'b0;
      end

      // ****************************************
      // Read capture and latency line
      // ****************************************
      next_st.dq_s1 = mem_dq_in;
      next_st.dq_s2 = st.dq_s1;
      next_st.rcap[st.cnt] = st.dq_s2;
      if (st.tick) begin
         en_in = adm_done && ((ctl_rdata_en & LMASK) != '0);
         next_st.en_sh = {st.en_sh[`CPH_MAX_RLAT-2:0], en_in};
         next_st.d_sh = {st.d_sh[`CPH_MAX_RLAT-2:0],
            cph_pkg::cph_rword_type'('0)};
         // Word finished now belongs to the read issued CAP_TICKS ago
         next_st.d_sh[CAP_TICKS] = next_st.rcap;
         next_st.rvalid = st.en_sh[RD_LAT-1];
         // Data is blanked so stale words never look valid
         next_st.rdata = st.en_sh[RD_LAT-1] ?
            st.d_sh[RD_LAT-1] : '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st         <= '0;
         st.mem.cmd <= cph_pkg::CPH_NOP;
      end else begin
         st <= next_st;
      end
   end

   assign ctl_tick        = st.tick;
   assign ctl_rdata       = st.rdata;
   assign ctl_rdata_valid = st.rvalid;
   assign ctl_cal_done    = adm_done;
   assign mem_cmd         = st.mem.cmd;
   assign mem_dq_out      = st.mem.wd;
   assign mem_dq_oe       = st.mem.wv;
   assign mem_dqs_oe      = st.mem.dqs;

endmodule

/* verification/cph_top_assertions.sv */
`timescale 1ns/10ps
`include "cph_params.svh"

module cph_top_assertions #(
   parameter int RATIO  = `CPH_RATIO,
   parameter int WR_LAT = `CPH_WR_LAT,
   parameter int RD_LAT = `CPH_RD_LAT
) (
   input wire logic                      clk_sys,
   input wire logic                      rst_n,
   input wire logic                      ctl_tick,
   input wire cph_pkg::cph_word_type     ctl_word,
   input wire logic [`CPH_MAX_RATIO-1:0] ctl_rdata_en,
   input wire cph_pkg::cph_rword_type    ctl_rdata,
   input wire logic                      ctl_rdata_valid,
   input wire logic                      ctl_cal_done,
   input wire logic [`CPH_LAT_W-1:0]     ctl_wlat,
   input wire logic [`CPH_LAT_W-1:0]     ctl_rlat,
   input wire cph_pkg::cph_cmd_type      mem_cmd,
   input wire logic [2*`CPH_DQ_W-1:0]    mem_dq_out,
   input wire logic                      mem_dq_oe,
   input wire logic                      mem_dqs_oe
);
   localparam int RD_DLY  = RD_LAT * RATIO + 1;
   localparam int RD_DLY2 = RD_DLY + 1;
   wire logic take;
   wire logic rd_req;
   assign take = ctl_tick && ctl_cal_done;
   assign rd_req = take && (|ctl_rdata_en[RATIO-1:0]);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_lanes;
      (mem_cmd == $past(ctl_word.lane[0].cmd)
         && mem_dq_out == $past(ctl_word.lane[0].wd))
      ##1 (mem_cmd == $past(ctl_word.lane[1].cmd, 2)
         && mem_dq_out == $past(ctl_word.lane[1].wd, 2));
   endsequence
   sequence s_oe;
      (mem_dq_oe == $past(ctl_word.lane[0].wv)
         && mem_dqs_oe == $past(ctl_word.lane[0].dqs))
      ##1 (mem_dq_oe == $past(ctl_word.lane[1].wv, 2)
         && mem_dqs_oe == $past(ctl_word.lane[1].dqs, 2));
   endsequence
   chk_tick_period: assert property (
      ctl_tick |=> !ctl_tick ##1 ctl_tick)
      else $error("controller tick spacing wrong");
   chk_lane_order: assert property (take |=> s_lanes)
      else $error("memory beat out of lane order");
   chk_lane_enables: assert property (take |=> s_oe)
      else $error("data or strobe enable out of step");
   chk_read_latency: assert property (
      rd_req |-> ##RD_DLY ctl_rdata_valid)
      else $error("read valid late or missing");
   chk_valid_cause: assert property (
      ctl_rdata_valid |-> $past(rd_req, RD_DLY) || $past(rd_req, RD_DLY2))
      else $error("read valid without a request");
   chk_rdata_idle: assert property (
      !ctl_rdata_valid |-> ctl_rdata == '0)
      else $error("read data not cleared");
   chk_lat_report: assert property (
      ctl_cal_done |-> ##1 (ctl_wlat == WR_LAT && ctl_rlat == RD_LAT))
      else $error("latency report wrong");
   chk_no_early_dq: assert property (
      !ctl_cal_done |-> !mem_dq_oe && !mem_dqs_oe)
      else $error("data driven before calibration");
   chk_done_sticky: assert property (ctl_cal_done |=> ctl_cal_done)
      else $error("calibration done dropped");
endmodule

/* verification/cph_ctl_model.sv */
`timescale 1ns/10ps
`include "cph_params.svh"

module cph_ctl_model (
   input  wire logic                  clk_sys,
   input  wire logic                  ctl_tick,
   input  wire logic [`CPH_LAT_W-1:0] ctl_wlat,
   output cph_pkg::cph_word_type      ctl_word,
   output logic [`CPH_MAX_RATIO-1:0]  ctl_rdata_en
);
   cph_pkg::cph_beat_type idle;
   initial begin
      idle = '{cmd: cph_pkg::CPH_NOP, default: '0};
      ctl_word = {`CPH_MAX_RATIO{idle}};
      ctl_rdata_en = '0;
   end
   // Words change only in a tick cycle and hold until the taking edge
   task automatic put(input cph_pkg::cph_beat_type b0,
                      input cph_pkg::cph_beat_type b1,
                      input logic [3:0]            en);
      do @(negedge clk_sys); while (ctl_tick !== 1'b1);
      ctl_word = {idle, idle, b1, b0};
      ctl_rdata_en = en;
   endtask
   task automatic do_write(input cph_pkg::cph_cmd_type c,
                           input logic [31:0]          d,
                           input logic                 two_t);
      cph_pkg::cph_beat_type w, s, v0, v1;
      w = idle;
      w.cmd = c;
      s = idle;
      s.dqs = 1'b1;
      v0 = '{cmd: cph_pkg::CPH_NOP, wd: d[15:0], wv: 1'b1, dqs: 1'b1};
      v1 = v0;
      v1.wd = d[31:16];
      put(w, two_t ? w : idle, 4'h0);
      for (int i = 1; i < ctl_wlat; i++) begin
         put(idle, (i == ctl_wlat - 1) ? s : idle, 4'h0);
      end
      put(v0, v1, 4'h0);
      put(idle, idle, 4'h0);
   endtask
   task automatic do_read(input cph_pkg::cph_cmd_type c);
      cph_pkg::cph_beat_type r;
      r = idle;
      r.cmd = c;
      put(idle, r, 4'h3);
      put(idle, idle, 4'h3);
      put(idle, idle, 4'h0);
   endtask
endmodule

/* verification/test_controller_phy_handshake.sv */
`timescale 1ns/10ps
`include "cph_params.svh"

module test_controller_phy_handshake;
   localparam cph_pkg::cph_cmd_type WR_CMD = '{cs_n: 1'b0, ras_n: 1'b1,
      cas_n: 1'b0, we_n: 1'b0, ba: '0, addr: '0};
   localparam cph_pkg::cph_cmd_type RD_CMD = '{cs_n: 1'b0, ras_n: 1'b1,
      cas_n: 1'b0, we_n: 1'b1, ba: '0, addr: '0};
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic rd_win = 1'b0;
   logic [15:0] mem_dq_in = 16'h0000;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   logic ctl_tick, ctl_rdata_valid, ctl_cal_done, mem_dq_oe, mem_dqs_oe;
   logic [3:0] ctl_rdata_en;
   logic [5:0] ctl_wlat, ctl_rlat;
   logic [15:0] mem_dq_out;
   cph_pkg::cph_word_type  ctl_word;
   cph_pkg::cph_rword_type ctl_rdata;
   cph_pkg::cph_cmd_type   mem_cmd;
   always #2.5 clk_sys = ~clk_sys;
   // Pins toggle outside reads so a stale value never passes for data
   always @(negedge clk_sys) mem_dq_in <= rd_win ? 16'hA55A : ~mem_dq_in;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         complete_run();
      end
   end
   cph_top #(.INIT_CYC(20)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .ctl_tick(ctl_tick), .ctl_word(ctl_word), .ctl_rdata(ctl_rdata),
      .ctl_rdata_en(ctl_rdata_en), .ctl_rdata_valid(ctl_rdata_valid),
      .ctl_cal_done(ctl_cal_done), .ctl_wlat(ctl_wlat),
      .ctl_rlat(ctl_rlat), .mem_cmd(mem_cmd), .mem_dq_out(mem_dq_out),
      .mem_dq_oe(mem_dq_oe), .mem_dqs_oe(mem_dqs_oe),
      .mem_dq_in(mem_dq_in));
   cph_ctl_model u_ctl (.clk_sys(clk_sys), .ctl_tick(ctl_tick),
      .ctl_wlat(ctl_wlat), .ctl_word(ctl_word),
      .ctl_rdata_en(ctl_rdata_en));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // A write issued during init must be swallowed by the admin block
   task automatic test_admin();
      logic [13:0] mr [4];
      int n;
      mr = '{`CPH_MR0, `CPH_MR1, `CPH_MR2, `CPH_MR3};
      n = 0;
      fork
         u_ctl.do_write(WR_CMD, 32'hFFFF_FFFF, 1'b0);
      join_none
      for (int i = 0; i < 200 && ctl_cal_done !== 1'b1; i++) begin
         @(negedge clk_sys);
         if ({mem_cmd.cs_n, mem_cmd.ras_n, mem_cmd.cas_n,
              mem_cmd.we_n} === 4'h0) begin
            check(mem_cmd.ba, n);
            check(mem_cmd.addr, mr[n]);
            n++;
         end
      end
      check(n, 4);
      @(negedge clk_sys);
      check({ctl_wlat, ctl_rlat}, {6'(`CPH_WR_LAT), 6'(`CPH_RD_LAT)});
   endtask
   task automatic test_write(input logic two_t);
      int cs_cnt, cs_at, oe_at, n;
      logic [15:0] dq [2];
      cs_cnt = 0;
      cs_at = -1;
      oe_at = -1;
      n = 0;
      fork
         u_ctl.do_write(WR_CMD, 32'h4433_2211, two_t);
         for (int i = 0; i < 24; i++) begin
            @(negedge clk_sys);
            if (mem_cmd.cs_n === 1'b0) begin
               cs_cnt++;
               if (cs_at < 0) cs_at = i;
            end
            if (mem_dq_oe === 1'b1) begin
               if (oe_at < 0) oe_at = i;
               if (n < 2) dq[n] = mem_dq_out;
               n++;
            end
         end
      join
      check(cs_cnt, two_t ? 2 : 1);
      check(oe_at - cs_at, `CPH_WR_LAT * `CPH_RATIO);
      check(n, 2);
      check({dq[1], dq[0]}, 32'h4433_2211);
   endtask
   task automatic test_read();
      int nv;
      logic [31:0] rd;
      nv = 0;
      rd_win = 1'b1;
      fork
         u_ctl.do_read(RD_CMD);
         for (int i = 0; i < 60; i++) begin
            @(negedge clk_sys);
            if (ctl_rdata_valid === 1'b1) begin
               if (nv == 0) rd = {ctl_rdata[1], ctl_rdata[0]};
               nv++;
            end
         end
      join
      rd_win = 1'b0;
      check(nv, 2 * `CPH_RATIO);
      check(rd, 32'hA55A_A55A);
   endtask
   initial begin
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      test_admin();
      test_write(1'b0);
      test_write(1'b1);
      test_read();
      complete_run();
   end
endmodule

bind cph_top cph_top_assertions #(.RATIO(RATIO), .WR_LAT(WR_LAT),
   .RD_LAT(RD_LAT)) u_chk (.clk_sys, .rst_n, .ctl_tick, .ctl_word,
   .ctl_rdata_en, .ctl_rdata, .ctl_rdata_valid, .ctl_cal_done, .ctl_wlat,
   .ctl_rlat, .mem_cmd, .mem_dq_out, .mem_dq_oe, .mem_dqs_oe);
